/* hw/encoder_position_counter.sv */
// encoder_position_counter: three incremental encoder channels with
// reload on index/origin and a position trigger per channel.
// assumes host configuration arrives as static levels on the clock domain
// and encoder pins are asynchronous.
//
// Function
// - cw/ccw mode: phase a pulse counts up
// - cw/ccw mode: phase b pulse counts down
// - x1: a leading b adds one per cycle
// - x1: b leading a subtracts one
// - x1 up on clock after a rises
// - x1 down on clock after a falls
// - x2 mode steps by two
// - x4 mode steps by four
// - reload value when index high, phases match
// - no reload without index in reload phase
// - reload wins over count step
// - reload done within one clock
// - counting resumes normally after reload
// - origin enabled: need index and origin high
// - origin enabled and low: reload ignored
// - trigger counts once pacer set, enabled
// - fire when count hits pacer multiple
// - config picks pin pulse or interrupt
// - pin pulse 200us, 2ms, 20ms, 200ms
// - three independent channels, own inputs
// - position readable anytime, undisturbed
`timescale 1ns/10ps
module encoder_position_counter #(
	parameter logic [encoder_pkg::PULSE_W-1:0] PULSE_CYC_200US =
		encoder_pkg::PULSE_CYC_0,
	parameter logic [encoder_pkg::PULSE_W-1:0] PULSE_CYC_2MS =
		encoder_pkg::PULSE_CYC_1,
	parameter logic [encoder_pkg::PULSE_W-1:0] PULSE_CYC_20MS =
		encoder_pkg::PULSE_CYC_2,
	parameter logic [encoder_pkg::PULSE_W-1:0] PULSE_CYC_200MS =
		encoder_pkg::PULSE_CYC_3
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] phase_a_in,
	input wire logic [2:0] phase_b_in,
	input wire logic [2:0] index_in,
	input wire logic [2:0] origin_in,
	input wire logic [2:0][1:0] enc_mode,
	input wire logic [2:0] reload_en,
	input wire logic [2:0] reload_phase_a,
	input wire logic [2:0] reload_phase_b,
	input wire logic [2:0] origin_en,
	input wire logic [2:0][31:0] reload_value,
	input wire logic [2:0] trig_en,
	input wire logic [2:0] trig_to_irq,
	input wire logic [2:0][31:0] pacer_num,
	input wire logic [2:0][1:0] pulse_width_sel,
	output logic [2:0][31:0] position,
	output logic [2:0] function_io_pin,
	output logic [2:0] trig_irq
);

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [encoder_pkg::SYNC_W-1:0] sync_bus;
	logic [2:0] a_s, b_s, z_s, o_s;

	input_sync #(
		.WIDTH(encoder_pkg::SYNC_W)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.async_in({origin_in, index_in, phase_b_in, phase_a_in}),
		.sync_out(sync_bus)
	);

	assign a_s = sync_bus[2:0];
	assign b_s = sync_bus[5:3];
	assign z_s = sync_bus[8:6];
	assign o_s = sync_bus[11:9];

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic signed [3:0] step_delta(
		input logic [1:0] mode,
		input logic ap,
		input logic a,
		input logic bp,
		input logic b
	);
		logic a_r, a_f, b_r, b_f, fwd, rev;
		logic signed [3:0] d;
		a_r = a & ~ap;
		a_f = ~a & ap;
		b_r = b & ~bp;
		b_f = ~b & bp;
		d = encoder_pkg::STEP_NONE;
		fwd = 1'b0;
		rev = 1'b0;
		unique case (mode)
			encoder_pkg::MODE_CW_CCW: begin
				// simultaneous cw and ccw pulses cancel out
				if (a_r & ~b_r)
					d = encoder_pkg::STEP_X1;
				else if (b_r & ~a_r)
					d = -encoder_pkg::STEP_X1;
			end
			encoder_pkg::MODE_X1: begin
				if (a_r & ~b)
					d = encoder_pkg::STEP_X1;
				else if (a_f & ~b)
					d = -encoder_pkg::STEP_X1;
			end
			encoder_pkg::MODE_X2: begin
				fwd = (a_r & ~b) | (a_f & b);
				rev = (a_r & b) | (a_f & ~b);
				if (fwd)
					d = encoder_pkg::STEP_X2;
				else if (rev)
					d = -encoder_pkg::STEP_X2;
			end
			encoder_pkg::MODE_X4: begin
				fwd = (a_r & ~b) | (a_f & b) | (b_r & a) | (b_f & ~a);
				rev = (a_r & b) | (a_f & ~b) | (b_r & ~a) | (b_f & a);
				// both phases moving in one sample is an illegal jump
				if (fwd & ~rev)
					d = encoder_pkg::STEP_X4;
				else if (rev & ~fwd)
					d = -encoder_pkg::STEP_X4;
			end
		endcase
		return d;
	endfunction

	function automatic logic [encoder_pkg::PULSE_W-1:0] width_cycles(
		input logic [1:0] sel
	);
		logic [encoder_pkg::PULSE_W-1:0] w;
		w = PULSE_CYC_200US;
		unique case (sel)
			encoder_pkg::WIDTH_200US: w = PULSE_CYC_200US;
			encoder_pkg::WIDTH_2MS: w = PULSE_CYC_2MS;
			encoder_pkg::WIDTH_20MS: w = PULSE_CYC_20MS;
			encoder_pkg::WIDTH_200MS: w = PULSE_CYC_200MS;
		endcase
		return w;
	endfunction

	// ****************************************
	// per channel decode
	// ****************************************
	logic [2:0] a_p_q, b_p_q;
	logic signed [3:0] delta [3];
	logic [2:0] step, reload;

	always_ff @(posedge clock) begin
		if (rst) begin
			a_p_q <= '0;
			b_p_q <= '0;
		end else begin
			a_p_q <= a_s;
			b_p_q <= b_s;
		end
	end

	always_comb begin
		for (int i = 0; i < encoder_pkg::NUM_CH; i++) begin
			delta[i] = step_delta(enc_mode[i], a_p_q[i], a_s[i],
				b_p_q[i], b_s[i]);
			step[i] = (delta[i] != encoder_pkg::STEP_NONE);
			// index level is sampled every clock, so it must be high
			// during some part of the chosen phase to be seen
			reload[i] = reload_en[i] & z_s[i]
				& (a_s[i] == reload_phase_a[i])
				& (b_s[i] == reload_phase_b[i])
				& (~origin_en[i] | o_s[i]);
		end
	end

	// ****************************************
	// position counters
	// ****************************************
	logic [2:0][31:0] pos_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < encoder_pkg::NUM_CH; i++)
				pos_q[i] <= encoder_pkg::POS_RESET;
		end else begin
			for (int i = 0; i < encoder_pkg::NUM_CH; i++) begin
				if (reload[i])
					pos_q[i] <= reload_value[i];
				else if (step[i])
					pos_q[i] <= pos_q[i]
						+ encoder_pkg::POS_W'(delta[i]);
			end
		end
	end

	// readout is the flop itself, so reading never disturbs counting
	assign position = pos_q;

	// ****************************************
	// position trigger
	// ****************************************
	logic [2:0][31:0] trig_cnt_q;
	logic [2:0] fire;

	always_comb begin
		for (int i = 0; i < encoder_pkg::NUM_CH; i++)
			fire[i] = trig_en[i] & step[i] & ~reload[i]
				& (pacer_num[i] != encoder_pkg::TRIG_CNT_RESET)
				& (trig_cnt_q[i] + 32'h1 == pacer_num[i]);
	end

	// counts counted steps, not their size; wraps at the pacer number
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < encoder_pkg::NUM_CH; i++)
				trig_cnt_q[i] <= encoder_pkg::TRIG_CNT_RESET;
		end else begin
			for (int i = 0; i < encoder_pkg::NUM_CH; i++) begin
				if (!trig_en[i])
					trig_cnt_q[i] <= encoder_pkg::TRIG_CNT_RESET;
				else if (fire[i])
					trig_cnt_q[i] <= encoder_pkg::TRIG_CNT_RESET;
				else if (step[i] & ~reload[i])
					trig_cnt_q[i] <= trig_cnt_q[i] + 32'h1;
			end
		end
	end

	// ****************************************
	// trigger outputs
	// ****************************************
	encoder_pkg::pulse_state_t pstate_q [3];
	logic [2:0][encoder_pkg::PULSE_W-1:0] pcnt_q;
	logic [2:0][encoder_pkg::PULSE_W-1:0] width_q;
	logic [2:0] pin_q, irq_q;

	// a trigger during a running pulse is dropped rather than stretching it
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < encoder_pkg::NUM_CH; i++) begin
				pstate_q[i] <= encoder_pkg::PULSE_IDLE;
				pcnt_q[i] <= '0;
				width_q[i] <= '0;
			end
			pin_q <= '0;
		end else begin
			for (int i = 0; i < encoder_pkg::NUM_CH; i++) begin
				unique case (pstate_q[i])
					encoder_pkg::PULSE_IDLE: begin
						if (fire[i] & ~trig_to_irq[i]) begin
							pstate_q[i] <= encoder_pkg::PULSE_HIGH;
							pin_q[i] <= 1'b1;
							width_q[i] <= width_cycles(pulse_width_sel[i]);
							pcnt_q[i] <= width_cycles(pulse_width_sel[i])
								- 23'h1;
						end
					end
					encoder_pkg::PULSE_HIGH: begin
						if (pcnt_q[i] == '0) begin
							pstate_q[i] <= encoder_pkg::PULSE_IDLE;
							pin_q[i] <= 1'b0;
						end else begin
							pcnt_q[i] <= pcnt_q[i] - 23'h1;
						end
					end
					default: begin
						pstate_q[i] <= encoder_pkg::PULSE_IDLE;
						pin_q[i] <= 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			irq_q <= '0;
		else
			irq_q <= fire & trig_to_irq;
	end

	assign function_io_pin = pin_q;
	assign trig_irq = irq_q;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	logic [2:0][encoder_pkg::PULSE_W-1:0] high_len_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			high_len_q <= '0;
		end else begin
			for (int i = 0; i < encoder_pkg::NUM_CH; i++)
				high_len_q[i] <= pin_q[i] ? high_len_q[i] + 23'h1 : '0;
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_chk
		a_cw_up: assert property (
			enc_mode[g] == encoder_pkg::MODE_CW_CCW && !reload[g]
			&& a_s[g] && !a_p_q[g] && !(b_s[g] && !b_p_q[g])
			|=> pos_q[g] == $past(pos_q[g]) + 32'h1)
			else $error("cw pulse did not count up");
		a_ccw_down: assert property (
			enc_mode[g] == encoder_pkg::MODE_CW_CCW && !reload[g]
			&& b_s[g] && !b_p_q[g] && !(a_s[g] && !a_p_q[g])
			|=> pos_q[g] == $past(pos_q[g]) - 32'h1)
			else $error("ccw pulse did not count down");
		a_x1_up: assert property (
			enc_mode[g] == encoder_pkg::MODE_X1 && !reload[g]
			&& $rose(a_s[g]) && !b_s[g]
			|=> pos_q[g] == $past(pos_q[g]) + 32'h1)
			else $error("x1 forward step wrong");
		a_x1_down: assert property (
			enc_mode[g] == encoder_pkg::MODE_X1 && !reload[g]
			&& $fell(a_s[g]) && !b_s[g]
			|=> pos_q[g] == $past(pos_q[g]) - 32'h1)
			else $error("x1 reverse step wrong");
		a_x1_quiet: assert property (
			enc_mode[g] == encoder_pkg::MODE_X1 && !reload[g]
			&& $stable(a_s[g]) |=> $stable(pos_q[g]))
			else $error("x1 counted without a phase a edge");
		a_x2_step: assert property (
			enc_mode[g] == encoder_pkg::MODE_X2 && !reload[g]
			&& $fell(a_s[g]) && b_s[g]
			|=> pos_q[g] == $past(pos_q[g]) + 32'h2)
			else $error("x2 step not two");
		a_x4_step: assert property (
			enc_mode[g] == encoder_pkg::MODE_X4 && !reload[g]
			&& $rose(b_s[g]) && a_s[g] && $stable(a_s[g])
			|=> pos_q[g] == $past(pos_q[g]) + 32'h4)
			else $error("x4 step not four");
		a_reload_wins: assert property (
			reload_en[g] && z_s[g] && a_s[g] == reload_phase_a[g]
			&& b_s[g] == reload_phase_b[g] && (!origin_en[g] || o_s[g])
			|=> pos_q[g] == $past(reload_value[g]))
			else $error("reload not applied within one clock");
		a_origin_block: assert property (
			origin_en[g] && !o_s[g] && !step[g] |=> $stable(pos_q[g]))
			else $error("reload taken with origin low");
		a_trig_idle: assert property (
			!trig_en[g] |=> trig_cnt_q[g] == '0 && !irq_q[g])
			else $error("trigger counted while disabled");
		a_irq_route: assert property (
			fire[g] && trig_to_irq[g] |=> irq_q[g] && !$rose(pin_q[g]))
			else $error("interrupt route drove the pin");
		a_pulse_len: assert property (
			$fell(pin_q[g]) |-> high_len_q[g] == width_q[g])
			else $error("pin pulse width wrong");
		c_reload: cover property (reload[g] && step[g]);
		c_pin_pulse: cover property ($fell(pin_q[g]));
		c_irq: cover property (irq_q[g]);
	end

endmodule // encoder_position_counter

/* hw/encoder_pkg.sv */
// encoder_pkg: constants and types shared by the encoder position counter.
// assumes a single 20 MHz counting clock drives every consumer.
package encoder_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_CH = 3;
	localparam int POS_W = 32;
	localparam int PULSE_W = 23;
	localparam int SYNC_W = 4 * NUM_CH;

	// ****************************************
	// clock and pulse timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int PULSE_T0_US = 200;
	localparam int PULSE_T1_US = 2000;
	localparam int PULSE_T2_US = 20000;
	localparam int PULSE_T3_US = 200000;
	localparam logic [PULSE_W-1:0] PULSE_CYC_0 =
		PULSE_W'(PULSE_T0_US * 1000 / CLK_PERIOD_NS);
	localparam logic [PULSE_W-1:0] PULSE_CYC_1 =
		PULSE_W'(PULSE_T1_US * 1000 / CLK_PERIOD_NS);
	localparam logic [PULSE_W-1:0] PULSE_CYC_2 =
		PULSE_W'(PULSE_T2_US * 1000 / CLK_PERIOD_NS);
	localparam logic [PULSE_W-1:0] PULSE_CYC_3 =
		PULSE_W'(PULSE_T3_US * 1000 / CLK_PERIOD_NS);

	// ****************************************
	// pulse width selections
	// ****************************************
	localparam logic [1:0] WIDTH_200US = 2'h0;
	localparam logic [1:0] WIDTH_2MS = 2'h1;
	localparam logic [1:0] WIDTH_20MS = 2'h2;
	localparam logic [1:0] WIDTH_200MS = 2'h3;

	// ****************************************
	// decoder modes and step sizes
	// ****************************************
	localparam logic [1:0] MODE_CW_CCW = 2'h0;
	localparam logic [1:0] MODE_X1 = 2'h1;
	localparam logic [1:0] MODE_X2 = 2'h2;
	localparam logic [1:0] MODE_X4 = 2'h3;
	localparam logic signed [3:0] STEP_NONE = 4'sh0;
	localparam logic signed [3:0] STEP_X1 = 4'sh1;
	localparam logic signed [3:0] STEP_X2 = 4'sh2;
	localparam logic signed [3:0] STEP_X4 = 4'sh4;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [POS_W-1:0] POS_RESET = 32'h0;
	localparam logic [POS_W-1:0] TRIG_CNT_RESET = 32'h0;

	typedef enum logic [1:0] {
		PULSE_IDLE = 2'b01,
		PULSE_HIGH = 2'b10
	} pulse_state_t;

endpackage

/* hw/input_sync.sv */
// input_sync: two flip-flop synchroniser for a group of pin levels.
// assumes the inputs are levels from outside the clock domain.
`timescale 1ns/10ps
module input_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// meta_q feeds only the second stage; nothing else may look at it
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // input_sync

/* verif/quad_encoder_model.sv */
// quad_encoder_model: far-side incremental encoders for three channels.
// assumes tasks are entered at a falling clock edge by the bench.
`timescale 1ns/10ps
module quad_encoder_model (
	input wire logic clock,
	output logic [2:0] a,
	output logic [2:0] b,
	output logic [2:0] z,
	output logic [2:0] org
);
	initial begin
		a = 3'h0;
		b = 3'h0;
		z = 3'h0;
		org = 3'h0;
	end

	// ****************************************
	// pin moves
	// ****************************************
	// hold of at least 2 keeps each level past both synchroniser stages
	task automatic put(input int ch, input bit va, input bit vb,
		input bit vz, input int hold);
		a[ch] = va;
		b[ch] = vb;
		z[ch] = vz;
		repeat (hold) @(negedge clock);
	endtask

	// origin level is driven here so the pin keeps a single owner
	task automatic set_origin(input int ch, input bit v);
		org[ch] = v;
	endtask

	// cw: one pulse on a or b; quadrature: one full cycle, index in 10
	task automatic turn(input int ch, input bit cw, input bit fwd,
		input bit zph, input int hold);
		put(ch, fwd, !fwd, zph & fwd, hold);
		if (!cw) begin
			put(ch, 1'b1, 1'b1, 1'b0, hold);
			put(ch, !fwd, fwd, zph & !fwd, hold);
		end
		put(ch, 1'b0, 1'b0, 1'b0, hold);
	endtask
endmodule // quad_encoder_model

/* verif/test_encoder_position_counter.sv */
// test_encoder_position_counter: self-checking bench for the encoder block.
// assumes the encoder model drives the pins; pulse widths are shortened.
`timescale 1ns/10ps
module test_encoder_position_counter;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [2:0] a, b, z, org;
	logic [2:0][1:0] enc_mode = '0;
	logic [2:0] reload_en = 3'h0;
	logic [2:0] reload_phase_a = 3'h0;
	logic [2:0] reload_phase_b = 3'h0;
	logic [2:0] origin_en = 3'h0;
	logic [2:0][31:0] reload_value = '0;
	logic [2:0] trig_en = 3'h0;
	logic [2:0] trig_to_irq = 3'h0;
	logic [2:0][31:0] pacer_num = '0;
	logic [2:0][1:0] pulse_width_sel = '0;
	logic [2:0][31:0] position;
	logic [2:0] function_io_pin;
	logic [2:0] trig_irq;
	logic [31:0] seed = 32'h0000EC63;
	logic [31:0] r;
	int exp_pos[3] = '{0, 0, 0};
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	int irq_n = 0;
	int hi_n = 0;
	int other_n = 0;

	always #25 clock = ~clock;

	encoder_position_counter #(
		.PULSE_CYC_200US(23'h4),
		.PULSE_CYC_2MS(23'h8),
		.PULSE_CYC_20MS(23'h10),
		.PULSE_CYC_200MS(23'h20)
	) dut (
		.clock(clock), .rst(rst), .phase_a_in(a), .phase_b_in(b),
		.index_in(z), .origin_in(org), .enc_mode(enc_mode),
		.reload_en(reload_en), .reload_phase_a(reload_phase_a),
		.reload_phase_b(reload_phase_b), .origin_en(origin_en),
		.reload_value(reload_value), .trig_en(trig_en),
		.trig_to_irq(trig_to_irq), .pacer_num(pacer_num),
		.pulse_width_sel(pulse_width_sel), .position(position),
		.function_io_pin(function_io_pin), .trig_irq(trig_irq)
	);

	quad_encoder_model enc (.clock(clock), .a(a), .b(b), .z(z), .org(org));

	// ****************************************
	// watchers and timeout
	// ****************************************
	// outputs move on the rising edge, so look at them half a period later
	always @(negedge clock) begin
		cyc++;
		if (trig_irq[0] === 1'b1)
			irq_n++;
		if (function_io_pin[0] === 1'b1)
			hi_n++;
		// channels 1 and 2 never enable a trigger
		if (trig_irq[2:1] !== 2'h0 || function_io_pin[2:1] !== 2'h0)
			other_n++;
		if (cyc == 6000) begin
			miscompares++;
			final_report();
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] next_rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// quadrature x2 counts every a edge, x4 every edge: whole-cycle sums
	function automatic int delta(input logic [1:0] m, input bit fwd);
		int mag;
		case (m)
			encoder_pkg::MODE_X2: mag = 4;
			encoder_pkg::MODE_X4: mag = 16;
			default: mag = 1;
		endcase
		return fwd ? mag : -mag;
	endfunction

	task automatic check_pos(input int ch, input logic [31:0] want);
		samples_checked++;
		if (position[ch] !== want) begin
			miscompares++;
			$display("[ERR] %0t position ch%0d got %h want %h", $time, ch,
				position[ch], want);
		end
	endtask

	task automatic check_cnt(input int got, input int want, input string what);
		samples_checked++;
		if (got != want) begin
			miscompares++;
			$display("[ERR] %0t %s got %0d want %0d", $time, what, got, want);
		end
	endtask

	task automatic settle_check();
		repeat (4) @(negedge clock);
		for (int c = 0; c < 3; c++)
			check_pos(c, 32'(exp_pos[c]));
	endtask

	task automatic op(input int ch, input logic [1:0] m, input bit fwd,
		input bit zph, input int hold);
		enc_mode[ch] = m;
		enc.turn(ch, m == encoder_pkg::MODE_CW_CCW, fwd, zph, hold);
		exp_pos[ch] += delta(m, fwd);
	endtask

	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (12) @(negedge clock);
		rst = 1'b0;
		repeat (2) @(negedge clock);
		settle_check();
		enc_mode[1] = encoder_pkg::MODE_X1;
		repeat (3) @(negedge clock);
		enc.put(1, 1'b1, 1'b0, 1'b0, 0);
		repeat (2) @(posedge clock);
		#1 check_pos(1, 32'(exp_pos[1]));
		@(posedge clock);
		#1 exp_pos[1]++;
		check_pos(1, 32'(exp_pos[1]));
		@(negedge clock);
		enc.put(1, 1'b1, 1'b1, 1'b0, 2);
		enc.put(1, 1'b0, 1'b1, 1'b0, 2);
		enc.put(1, 1'b0, 1'b0, 1'b0, 2);
		settle_check();
		for (int i = 0; i < 32; i++) begin
			r = next_rnd();
			op(int'(r[7:0]) % 3, 2'(i), (i < 8) ? i[2] : r[9], 1'b0,
				2 + int'(r[15:8]) % 3);
			settle_check();
		end
		// reload on channel 2, phase a high b low
		reload_en[2] = 1'b1;
		reload_phase_a[2] = 1'b1;
		reload_value[2] = next_rnd();
		op(2, encoder_pkg::MODE_X1, 1'b1, 1'b1, 2);
		exp_pos[2] = int'(reload_value[2]);
		settle_check();
		op(2, encoder_pkg::MODE_X1, 1'b1, 1'b0, 3);
		settle_check();
		enc.put(2, 1'b0, 1'b0, 1'b1, 4);
		enc.put(2, 1'b0, 1'b0, 1'b0, 1);
		settle_check();
		origin_en[2] = 1'b1;
		op(2, encoder_pkg::MODE_X1, 1'b1, 1'b1, 2);
		settle_check();
		enc.set_origin(2, 1'b1);
		reload_value[2] = next_rnd();
		op(2, encoder_pkg::MODE_X1, 1'b0, 1'b1, 2);
		// reverse cycle: the a fall after the reload phase still counts
		exp_pos[2] = int'(reload_value[2])
			+ delta(encoder_pkg::MODE_X1, 1'b0);
		settle_check();
		// trigger as interrupt: ten x2 steps, pacer three
		pacer_num[0] = 32'h3;
		trig_to_irq[0] = 1'b1;
		trig_en[0] = 1'b1;
		irq_n = 0;
		for (int i = 0; i < 5; i++)
			op(0, encoder_pkg::MODE_X2, 1'b1, 1'b0, 2);
		settle_check();
		check_cnt(irq_n, 3, "irq events");
		// trigger as pin pulse, every width
		trig_to_irq[0] = 1'b0;
		pacer_num[0] = 32'h1;
		for (int s = 0; s < 4; s++) begin
			trig_en[0] = 1'b0;
			pulse_width_sel[0] = 2'(s);
			@(negedge clock);
			trig_en[0] = 1'b1;
			hi_n = 0;
			irq_n = 0;
			op(0, encoder_pkg::MODE_X1, s[0], 1'b0, 2);
			repeat (40) @(negedge clock);
			check_cnt(hi_n, 4 << s, "pin width");
			check_cnt(irq_n, 0, "irq in pin mode");
		end
		settle_check();
		check_cnt(other_n, 0, "idle channel trigger");
		final_report();
	end
endmodule // test_encoder_position_counter
